// file: rtl/secc_ctrl.sv
// APB serial memory command controller with automatic station address load
//
// Overview of operation
// [RQ1] Busy write starts selected command at address
// [RQ2] Busy holds until done; read data valid
// [RQ3] Software leaves command, data alone while busy
// [RQ4] No new command before previous completes
// [RQ5] Absent memory write: busy until time-out
// [RQ6] Busy high after reset until load ends
// [RQ7] Command field decodes eight operations
// [RQ8] Reload fails without A5 signature byte
// [RQ9] No response in 30 ms aborts, flags
// [RQ10] Data pin high: commands never time out
// [RQ11] Data pin low: only erase/write time out
// [RQ12] Loaded bit set on successful address load
// [RQ13] Eight-bit address is a byte location
// [RQ14] Data register holds eight-bit byte only
// [RQ15] Bytes 1-4 fill low station word
// [RQ16] Bytes 5-6 fill high station word
// [RQ17] Enable/disable gate memory erase and write
// [RQ18] Write, write-all, erase, erase-all act
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module secc_ctrl #(
    parameter int TMO_CYCLES = secc_pkg::TMO_CYC
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                ce,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    output logic                     irq,
    input  wire logic                mem_din,
    output secc_pkg::secc_pin_s      mem_pin
);
    import secc_pkg::*;

    localparam logic [TCW-1:0] TMO_LAST = TCW'(TMO_CYCLES - 1);
    localparam logic [TCW-1:0] POLL_SETTLE = TCW'(SYNC_DLY);

    secc_state_e     st_reg;
    secc_cmd_e       cmd_reg;
    logic            busy_reg, tmo_reg, loaded_reg, rl_reg;
    logic [7:0]      addr_reg, data_reg, rx_reg;
    logic [2:0]      idx_reg, div_reg, ists_reg, imsk_reg, ev_reg;
    logic [4:0]      nbit_reg;
    logic [18:0]     sh_reg;
    logic [TCW-1:0]  tcnt_reg;
    logic [31:0]     stal_reg;
    logic [15:0]     stah_reg;
    logic            din_meta, din_s;
    logic            acc, wr, start, fin, tmo_hit, has_data, wr_type, rd_phase, settled;
    secc_cmd_e       cur_cmd;
    logic [7:0]      cur_addr;
    logic [31:0]     rdata_c;
    logic            known_c;

    // ************************************************************
    // Pin synchroniser and decode
    // ************************************************************
    // Data pin arrives from off chip: two flops before any use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            din_meta <= 1'b0;
            din_s    <= 1'b0;
        end else if (ce) begin
            din_meta <= mem_din;
            din_s    <= din_meta;
        end
    end

    // Access completes on the second access cycle
    assign acc = psel & penable & pready;
    assign wr  = acc & pwrite;
    // [RQ1] Busy write starts
    // [RQ4] Start refused while busy
    assign start = wr && paddr == OFF_CMD && pwdata[BUSY_BIT] && !busy_reg;
    assign cur_cmd  = rl_reg ? CMD_READ : cmd_reg;
    assign cur_addr = rl_reg ? {5'h00, idx_reg} : addr_reg;
    assign has_data = cur_cmd == CMD_READ || cur_cmd == CMD_WRITE || cur_cmd == CMD_WRITE_ALL;
    // [RQ11] Only erase/write poll
    assign wr_type  = cur_cmd == CMD_WRITE || cur_cmd == CMD_WRITE_ALL ||
                      cur_cmd == CMD_ERASE || cur_cmd == CMD_ERASE_ALL;
    assign rd_phase = cur_cmd == CMD_READ && nbit_reg <= NBIT_BYTE;
    // [RQ9] Poll window expiry
    // [RQ10] High pin ends poll
    assign settled = tcnt_reg >= POLL_SETTLE; // Synced pin still shows the gap level before this
    assign tmo_hit = st_reg == S_POLL && !din_s && tcnt_reg == TMO_LAST;
    assign fin = (st_reg == S_GAP && div_reg == DIV_LAST && !wr_type) ||
                 (st_reg == S_POLL && ((din_s && settled) || tcnt_reg == TMO_LAST));

    // [RQ7] Command decode to serial opcode
    // [RQ13] Address as byte location
    // [RQ17] Enable and disable opcodes
    // [RQ18] Write, erase and bulk opcodes
    function automatic logic [9:0] mw_word(input secc_cmd_e c, input logic [7:0] a);
        case (c)
            CMD_READ:  mw_word = {OP_READ, a};
            CMD_WRITE: mw_word = {OP_WRITE, a};
            CMD_ERASE: mw_word = {OP_ERASE, a};
            CMD_WR_ON:     mw_word = {OP_EXT, EXT_WR_ON};
            CMD_WR_OFF:    mw_word = {OP_EXT, EXT_WR_OFF};
            CMD_ERASE_ALL: mw_word = {OP_EXT, EXT_ERASE_ALL};
            CMD_WRITE_ALL: mw_word = {OP_EXT, EXT_WRITE_ALL};
            default:   mw_word = {OP_READ, a};
        endcase
    endfunction

    // ************************************************************
    // Command engine
    // ************************************************************
    // Sequencer, command registers and serial pins share one owner
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // [RQ6] Busy and load from reset
            st_reg     <= S_START;
            busy_reg   <= 1'b1;
            rl_reg     <= 1'b1;
            cmd_reg    <= CMD_READ;
            addr_reg   <= 8'h00;
            data_reg   <= 8'h00;
            tmo_reg    <= 1'b0;
            loaded_reg <= 1'b0;
            idx_reg    <= 3'h0;
            div_reg    <= 3'h0;
            nbit_reg   <= 5'h00;
            sh_reg     <= 19'h00000;
            rx_reg     <= 8'h00;
            tcnt_reg   <= '0;
            stal_reg   <= 32'hFFFFFFFF;
            stah_reg   <= 16'hFFFF;
            ev_reg     <= 3'h0;
            mem_pin    <= '{cs: 1'b0, sk: 1'b0, dout: 1'b0, oe_n: 1'b1};
        end else if (ce) begin
            ev_reg <= 3'h0;
            // [RQ3] Fields frozen while busy
            if (wr && !busy_reg && paddr == OFF_CMD) begin
                cmd_reg  <= secc_cmd_e'(pwdata[CMD_HI:CMD_LO]);
                addr_reg <= pwdata[7:0];
            end
            // [RQ14] Eight-bit data byte
            if (wr && !busy_reg && paddr == OFF_DATA)
                data_reg <= pwdata[7:0];
            div_reg <= (st_reg == S_IDLE || st_reg == S_START) ? 3'h0 : div_reg + 3'h1;
            case (st_reg)
                S_IDLE: begin
                    if (start) begin
                        busy_reg <= 1'b1;
                        tmo_reg  <= 1'b0;
                        idx_reg  <= 3'h0;
                        rl_reg   <= pwdata[CMD_HI:CMD_LO] == CMD_RELOAD;
                        if (pwdata[CMD_HI:CMD_LO] == CMD_RELOAD)
                            loaded_reg <= 1'b0;
                        st_reg   <= S_START;
                    end
                end
                S_START: begin
                    sh_reg      <= {1'b1, mw_word(cur_cmd, cur_addr), data_reg};
                    nbit_reg    <= has_data ? NBIT_DATA : NBIT_CMD;
                    mem_pin.cs  <= 1'b1;
                    st_reg      <= S_SHIFT;
                end
                S_SHIFT: begin
                    // Bit goes out with clock low, sampled on the rising edge
                    if (div_reg == 3'h0) begin
                        mem_pin.dout <= sh_reg[18];
                        mem_pin.oe_n <= rd_phase;
                    end
                    if (div_reg == DIV_HALF) begin
                        mem_pin.sk <= 1'b1;
                        rx_reg     <= {rx_reg[6:0], din_s};
                    end
                    if (div_reg == DIV_LAST) begin
                        mem_pin.sk <= 1'b0;
                        sh_reg     <= {sh_reg[17:0], 1'b0};
                        nbit_reg   <= nbit_reg - 5'h01;
                        if (nbit_reg == 5'h01) begin
                            mem_pin.cs   <= 1'b0;
                            mem_pin.oe_n <= 1'b1;
                            st_reg       <= S_GAP;
                        end
                    end
                end
                S_GAP: begin
                    // Select low for one bit time, then reselect to poll ready after erase/write
                    if (div_reg == DIV_LAST && wr_type) begin
                        mem_pin.cs <= 1'b1;
                        tcnt_reg   <= '0;
                        st_reg     <= S_POLL;
                    end
                end
                S_POLL: begin
                    tcnt_reg <= tcnt_reg + 1'b1;
                end
                default: st_reg <= S_IDLE;
            endcase
            // Completion overrides the per-state updates above
            if (fin) begin
                mem_pin.cs <= 1'b0;
                st_reg     <= S_IDLE;
                if (!rl_reg) begin
                    // [RQ2] Busy drops with read byte
                    // [RQ5] Write clears at time-out
                    busy_reg         <= 1'b0;
                    ev_reg[EV_DONE]  <= 1'b1;
                    tmo_reg          <= tmo_hit;
                    ev_reg[EV_TMO]   <= tmo_hit;
                    if (cmd_reg == CMD_READ)
                        data_reg <= rx_reg;
                // [RQ8] Missing signature ends load
                end else if (idx_reg == 3'h0 && rx_reg != SIGNATURE) begin
                    busy_reg        <= 1'b0;
                    rl_reg          <= 1'b0;
                    ev_reg[EV_DONE] <= 1'b1;
                end else begin
                    // [RQ15] Low station word bytes
                    if (idx_reg != 3'h0 && idx_reg <= IDX_LO_END)
                        stal_reg[{idx_reg[1:0] - 2'h1, 3'h0} +: 8] <= rx_reg;
                    // [RQ16] High station word bytes
                    if (idx_reg == IDX_HI_LO)
                        stah_reg[7:0] <= rx_reg;
                    if (idx_reg == IDX_LAST)
                        stah_reg[15:8] <= rx_reg;
                    if (idx_reg == IDX_LAST) begin
                        // [RQ12] Load success flag
                        busy_reg        <= 1'b0;
                        rl_reg          <= 1'b0;
                        loaded_reg      <= 1'b1;
                        ev_reg          <= 3'h5;
                    end else begin
                        idx_reg <= idx_reg + 3'h1;
                        st_reg  <= S_START;
                    end
                end
            end
        end
    end

    // ************************************************************
    // Bus slave and interrupts
    // ************************************************************
    // Read view of every register
    always_comb begin
        rdata_c = '0;
        known_c = 1'b1;
        case (paddr)
            OFF_CMD: begin
                rdata_c[BUSY_BIT]       = busy_reg;
                rdata_c[CMD_HI:CMD_LO]  = cmd_reg;
                rdata_c[TMO_BIT]        = tmo_reg;
                rdata_c[LOADED_BIT]     = loaded_reg;
                rdata_c[7:0]            = addr_reg;
            end
            OFF_DATA: rdata_c[7:0]  = data_reg;
            OFF_ISTS: rdata_c[2:0]  = ists_reg;
            OFF_IMSK: rdata_c[2:0]  = imsk_reg;
            OFF_STAL: rdata_c       = stal_reg;
            OFF_STAH: rdata_c[15:0] = stah_reg;
            default:  known_c       = 1'b0;
        endcase
    end

    // One wait state: answer is registered on the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~known_c;
            if (psel & penable & ~pready & ~pwrite)
                prdata <= rdata_c;
        end
    end

    // Sticky events: set beats a same-cycle write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ists_reg <= 3'h0;
            imsk_reg <= 3'h0;
            irq      <= 1'b0;
        end else if (ce) begin
            if (wr && paddr == OFF_IMSK)
                imsk_reg <= pwdata[2:0];
            ists_reg <= (ists_reg & ~((wr && paddr == OFF_ISTS) ? pwdata[2:0] : 3'h0)) | ev_reg;
            irq      <= |(ists_reg & imsk_reg);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_fin_host; ce && fin && !rl_reg; endsequence
    sequence s_fin_load; ce && fin && rl_reg; endsequence

    property p_start;
        ce && start |=> busy_reg && st_reg == S_START ##1 ce [*1] ##0 1;
    endproperty
    a_start: assert property (p_start) else $error("start did not set busy"); // [RQ1]
    property p_idle_free;
        st_reg == S_IDLE |-> !busy_reg;
    endproperty
    a_idle_free: assert property (p_idle_free) else $error("busy while idle"); // [RQ6]
    property p_read_data;
        s_fin_host ##0 cmd_reg == CMD_READ |=> !busy_reg && data_reg == $past(rx_reg);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read byte not posted"); // [RQ2]
    property p_tmo;
        ce && tmo_hit && !rl_reg |=> tmo_reg && !busy_reg && st_reg == S_IDLE;
    endproperty
    a_tmo: assert property (p_tmo) else $error("time-out not flagged"); // [RQ9]
    property p_poll_hi;
        ce && st_reg == S_POLL && din_s && settled |=> !tmo_reg && st_reg == S_IDLE;
    endproperty
    a_poll_hi: assert property (p_poll_hi) else $error("ready pin ignored"); // [RQ10]
    property p_no_poll;
        ce && st_reg == S_GAP && !wr_type |=> st_reg != S_POLL;
    endproperty
    a_no_poll: assert property (p_no_poll) else $error("non-write polled"); // [RQ11]
    property p_sig;
        s_fin_load ##0 idx_reg == 3'h0 && rx_reg != SIGNATURE |=> !busy_reg && !loaded_reg;
    endproperty
    a_sig: assert property (p_sig) else $error("unsigned memory accepted"); // [RQ8]
    property p_loaded;
        s_fin_load ##0 idx_reg == IDX_LAST |=> loaded_reg && stah_reg[15:8] == $past(rx_reg);
    endproperty
    a_loaded: assert property (p_loaded) else $error("load not reported"); // [RQ12]
endmodule

// file: rtl/secc_pkg.sv
// Constants, commands, states and pin bundle of the serial memory controller
package secc_pkg;
    // ************************************************************
    // Register map and field layout
    // ************************************************************
    localparam logic [7:0] OFF_CMD  = 8'hB0;
    localparam logic [7:0] OFF_DATA = 8'hB4;
    localparam logic [7:0] OFF_ISTS = 8'hB8;
    localparam logic [7:0] OFF_IMSK = 8'hBC;
    localparam logic [7:0] OFF_STAL = 8'hC0;
    localparam logic [7:0] OFF_STAH = 8'hC4;
    localparam int BUSY_BIT   = 31;
    localparam int CMD_HI     = 30;
    localparam int CMD_LO     = 28;
    localparam int TMO_BIT    = 9;
    localparam int LOADED_BIT = 8;
    localparam int EV_DONE    = 0;
    localparam int EV_TMO     = 1;
    localparam int EV_LOAD    = 2;
    // ************************************************************
    // Commands, serial opcodes, load sequence
    // ************************************************************
    typedef enum logic [2:0] {
        CMD_READ = 3'h0, CMD_WR_OFF = 3'h1, CMD_WR_ON = 3'h2, CMD_WRITE = 3'h3,
        CMD_WRITE_ALL = 3'h4, CMD_ERASE = 3'h5, CMD_ERASE_ALL = 3'h6, CMD_RELOAD = 3'h7
    } secc_cmd_e;
    typedef enum logic [2:0] {
        S_IDLE = 3'h0, S_START = 3'h1, S_SHIFT = 3'h2, S_GAP = 3'h3, S_POLL = 3'h4
    } secc_state_e;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] OP_EXT   = 2'h0;
    localparam logic [7:0] EXT_WR_ON     = 8'hC0;
    localparam logic [7:0] EXT_WR_OFF    = 8'h00;
    localparam logic [7:0] EXT_ERASE_ALL = 8'h80;
    localparam logic [7:0] EXT_WRITE_ALL = 8'h40;
    localparam logic [4:0] NBIT_CMD  = 5'h0B;
    localparam logic [4:0] NBIT_DATA = 5'h13;
    localparam logic [4:0] NBIT_BYTE = 5'h08;
    localparam logic [7:0] SIGNATURE = 8'hA5;
    localparam logic [2:0] IDX_LO_END = 3'h4;
    localparam logic [2:0] IDX_HI_LO  = 3'h5;
    localparam logic [2:0] IDX_LAST   = 3'h6;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_NS   = 100;
    localparam int SK_NS    = 800;
    localparam int TMO_MS   = 30;
    localparam int TMO_CYC  = TMO_MS * 1000000 / CLK_NS;
    localparam int TCW      = 19;
    localparam int SYNC_DLY = 2;
    localparam logic [2:0] DIV_LAST = 3'(SK_NS / CLK_NS - 1);
    localparam logic [2:0] DIV_HALF = 3'(SK_NS / CLK_NS / 2);
    // Pins toward the serial memory; oe_n low while driving data
    typedef struct packed {
        logic cs;
        logic sk;
        logic dout;
        logic oe_n;
    } secc_pin_s;
endpackage

// file: tb/secc_mem_model.sv
// Behavioural serial memory on the controller's data pin
`timescale 1ns/1ps
module secc_mem_model (
    input  wire logic        cs,
    input  wire logic        sk,
    input  wire logic        di,
    input  wire logic        present,
    input  wire logic [31:0] busy_ns,
    output logic             dq_oe,
    output logic             dq_out
);
    import secc_pkg::*;
    logic [7:0]  mem [256];
    logic [18:0] sr;
    logic [7:0]  rdv;
    int          cnt;
    logic        wen, rd, rdo, pend, poll, busy, rbit;
    // Image: signature, six station bytes, rest blank
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        for (int i = 0; i < 7; i++) mem[i] = (i == 0) ? 8'hA5 : 8'(i * 17);
        {wen, rd, rdo, pend, poll, busy, rbit} = '0;
        cnt = 0;
    end
    // A new frame restarts the bit count
    always @(posedge cs) begin
        cnt = 0;
        rd  = 1'h0;
        rdo = 1'h0;
    end
    // Bits are taken on the rising serial clock
    always @(posedge sk) begin
        if (cs && present) begin
            poll = 1'h0;
            sr   = {sr[17:0], di};
            cnt  = cnt + 1;
            if (cnt == 11) begin
                rd  = (sr[9:8] == OP_READ);
                rdv = mem[sr[7:0]];
                if (sr[9:0] == 10'h0C0) wen = 1'h1;
                if (sr[9:0] == 10'h000) wen = 1'h0;
                if (wen && sr[9:8] == OP_ERASE) mem[sr[7:0]] = 8'hFF;
                if (wen && sr[9:0] == 10'h080) foreach (mem[i]) mem[i] = 8'hFF;
                pend = wen && (sr[9:8] == OP_ERASE || sr[9:0] == 10'h080);
            end
            if (cnt == 19 && wen && sr[17:16] == OP_WRITE) mem[sr[15:8]] = sr[7:0];
            if (cnt == 19 && wen && sr[17:8] == 10'h040) foreach (mem[i]) mem[i] = sr[7:0];
            if (cnt == 19) pend = wen && (sr[17:16] == OP_WRITE || sr[17:8] == 10'h040);
        end
    end
    // Read data moves out after each falling serial clock, not before
    always @(negedge sk) begin
        if (rd && cnt < 19) begin
            rdo  = 1'h1;
            rbit = rdv[7];
            rdv  = {rdv[6:0], 1'h0};
        end
    end
    // Programming shows busy (low) for busy_ns after the frame closes
    always @(negedge cs) begin
        poll = pend;
        busy = pend;
        if (pend) begin
            pend = 1'h0;
            #(busy_ns) busy = 1'h0;
        end
    end
    assign dq_oe  = present && cs && (rdo || poll);
    assign dq_out = poll ? !busy : rbit;
endmodule

// file: tb/serial_eeprom_command_controller_tb_top.sv
// Self-checking bench for the serial memory command controller
`timescale 1ns/1ps
module serial_eeprom_command_controller_tb_top;
    import secc_pkg::*;
    // Short time-out keeps absent-memory runs brief
    localparam int TMO = 400;
    localparam logic [2:0] C_WDIS = 3'h1;
    localparam logic [2:0] C_WEN  = 3'h2;
    localparam logic [2:0] C_WALL = 3'h4;
    localparam logic [2:0] C_EALL = 3'h6;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, busy_ns;
    logic        present, pull_hi, m_oe, m_out, line;
    secc_pin_s   pins;
    int          mismatches = 0;
    int          samples_checked = 0;
    // Controller first, then the memory, else the pull resistor
    assign line = !pins.oe_n ? pins.dout : (m_oe ? m_out : pull_hi);
    secc_ctrl #(.TMO_CYCLES(TMO)) dut_u (
        .pclk(pclk), .presetn(presetn), .ce(1'h1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .mem_din(line), .mem_pin(pins)
    );
    secc_mem_model mem_u (
        .cs(pins.cs), .sk(pins.sk), .di(line), .present(present),
        .busy_ns(busy_ns), .dq_oe(m_oe), .dq_out(m_out)
    );
    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20) chk(32'h0, 32'h1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'h1, a, d, q, e);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'h0, a, 32'h0, q, e);
        chk(q, exp);
    endtask
    // Bounded busy poll; returns the last command word
    task automatic wait_idle(output logic [31:0] s);
        logic e;
        int   n;
        n = 0;
        do begin
            apb(1'h0, OFF_CMD, 32'h0, s, e);
            n++;
        end while (s[BUSY_BIT] !== 1'h0 && n < 3000);
        if (n >= 3000) chk(s, 32'h0);
    endtask
    task automatic cmd(input logic [2:0] c, input logic [7:0] a, output logic [31:0] s);
        wr(OFF_CMD, {1'h1, c, 20'h0, a});
        wait_idle(s);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_boot();
        logic [31:0] s;
        logic        e;
        apb(1'h0, OFF_CMD, 32'h0, s, e);
        chk(s[BUSY_BIT], 1'h1);
        wait_idle(s);
        chk(s[LOADED_BIT], 1'h1);
        rchk(OFF_STAL, 32'h44332211);
        rchk(OFF_STAH, 32'h00006655);
        rchk(OFF_ISTS, 32'h00000005);
        chk(irq, 1'h0);
        wr(OFF_IMSK, 32'h00000004);
        rchk(OFF_IMSK, 32'h00000004);
        chk(irq, 1'h1);
        wr(OFF_ISTS, 32'h00000005);
        rchk(OFF_ISTS, 32'h0);
        chk(irq, 1'h0);
        apb(1'h0, 8'hA0, 32'h0, s, e);
        chk(e, 1'h1);
        $display("t_boot done");
    endtask
    task automatic t_rw();
        logic [31:0] s;
        time         t;
        cmd(C_WEN, 8'h00, s);
        busy_ns <= 32'h00004E20;
        wr(OFF_DATA, 32'hFFFFFF5A);
        t = $time;
        wr(OFF_CMD, {1'h1, CMD_WRITE, 20'h0, 8'h01});
        wr(OFF_DATA, 32'h00000099);
        wait_idle(s);
        chk($time - t > 20000, 1'h1);
        rchk(OFF_DATA, 32'h0000005A);
        busy_ns <= 32'h000000C8;
        wr(OFF_DATA, 32'h0);
        cmd(CMD_READ, 8'h01, s);
        rchk(OFF_DATA, 32'h0000005A);
        cmd(CMD_RELOAD, 8'h00, s);
        chk(s[LOADED_BIT], 1'h1);
        rchk(OFF_STAL, 32'h4433225A);
        $display("t_rw done");
    endtask
    task automatic t_bulk();
        logic [31:0] s;
        wr(OFF_DATA, 32'h000000C3);
        cmd(C_WALL, 8'h00, s);
        cmd(CMD_READ, 8'h80, s);
        rchk(OFF_DATA, 32'h000000C3);
        cmd(CMD_ERASE, 8'h80, s);
        cmd(CMD_READ, 8'h80, s);
        rchk(OFF_DATA, 32'h000000FF);
        cmd(CMD_RELOAD, 8'h00, s);
        chk(s[LOADED_BIT], 1'h0);
        rchk(OFF_STAL, 32'h4433225A);
        cmd(C_WDIS, 8'h00, s);
        wr(OFF_DATA, 32'h0000003C);
        cmd(CMD_WRITE, 8'h80, s);
        cmd(CMD_READ, 8'h80, s);
        rchk(OFF_DATA, 32'h000000FF);
        cmd(C_WEN, 8'h00, s);
        cmd(C_EALL, 8'h00, s);
        cmd(CMD_READ, 8'h10, s);
        rchk(OFF_DATA, 32'h000000FF);
        $display("t_bulk done");
    endtask
    // Absent memory, pull low then high, every command code
    task automatic t_tmo();
        logic [31:0] s;
        time         t;
        logic        tm;
        present <= 1'h0;
        wr(OFF_IMSK, 32'h00000002);
        for (int p = 0; p < 2; p++) begin
            pull_hi <= p[0];
            for (int c = 0; c < 8; c++) begin
                tm = (p == 0) && (c inside {3, 4, 5, 6});
                wr(OFF_ISTS, 32'h00000007);
                t = $time;
                cmd(3'(c), 8'h05, s);
                repeat (2) @(posedge pclk);
                chk(s[TMO_BIT], tm);
                chk($time - t > TMO * 100, tm);
                chk(irq, tm);
            end
        end
        $display("t_tmo done");
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // 10 MHz clock
    initial begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end
    // Watchdog well beyond the expected run
    initial begin
        #6000000;
        mismatches++;
        report_and_stop();
    end
    // Reset, then the scenarios in order
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {present, pull_hi} = 2'h3;
        busy_ns = 32'h000000C8;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        t_boot();
        t_rw();
        t_bulk();
        t_tmo();
        report_and_stop();
    end
endmodule
